//--- monitor_config_control.sv
// Purpose: configuration and control bank of a hardware monitor
// Assumes: pins synchronous to clk; srst is the power-on reset
// Notes: value and limit registers live outside, via ext port
// Behaviour
// - sample reset pin once after power-up; high enters tree test
// - in tree test, test output follows NAND of all tree inputs
// - power-up initializes config, mode, mask, test, output, trips
// - soft init restores same set except test and analog output
// - writing one to primary bit 7 starts init, bit self-clears
// - after power-up converter stopped, interrupt-line clear set
// - primary bit 0 runs monitoring loop; zero means low power
// - serial bus access to all registers works in low power
// - primary bit 1 enables interrupt output
// - primary bit 2 enables thermal-alarm output
// - primary bit 3 releases interrupt and halts monitoring
// - primary bit 4 drives one long low pulse on reset pin
// - writing primary bit 6 clears pending thermal alarm
// - secondary bit 0 masks temperature interrupts at interrupt pin
// - secondary bits 1,2 lock trip registers until power-on reset
// - secondary bit 3 selects one-time or ACPI alarm mode
// - conversions and fan measurements start together
// - measured values readable at any time
// - test bit 0 shuts down output and monitoring, keeps registers
// - host writes write-only pointer addressing all registers
// - reset pulse only if mask bit 7 enabled; request self-clears
// - external low on reset pin restores defaults, not output
// - secondary configuration register sits at 4Ah
`timescale 1ns/1ns
module monitor_config_control
   import monitor_pkg::*;
#(
   parameter int TREE_W = 8,
   parameter int PULSE_CYC = RST_PULSE_CYC
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic rstPinIn,
   output logic rstPinOut,
   output logic rstPinOeN,
   input wire logic [TREE_W-1:0] treeIn,
   input wire logic treeAddrIn,
   output logic treeAddrOut,
   output logic treeAddrOeN,
   input wire logic tempIrq,
   input wire logic otherIrq,
   input wire logic thermEvent,
   output logic intPinOut,
   output logic intPinOeN,
   output logic thermPinOut,
   output logic thermPinOeN,
   output logic monitorRun,
   output logic convStart,
   output logic fanStart,
   output logic shutdown,
   output logic aoutEnable,
   output logic [7:0] aoutValue,
   output logic thermAcpi,
   output logic [7:0] chanMode,
   output logic [7:0] extAddr,
   input wire logic [7:0] extRdData,
   output logic nandMode
);
   logic [7:0] ptr_ff, cfg1_ff, cfg2_ff, mask2_ff, test_ff;
   logic [7:0] aout_ff, chmode_ff, tripLoc_ff, tripRem_ff;
   logic strapDone_ff, nandMode_ff, addrSel_ff, runQ_ff;
   logic thermLatch_ff, intDrv_ff, treeOut_ff;
   logic byteStb, firstData, rdStb, pulseBusy, pulseGo;
   logic [7:0] byteData, rdData;
   logic wrStb, pinRst, initReq, softRst, run;

   ////////////////////////////////////////////////////////////////
   // serial bus front end
   serial_slave u_slave (
      .clk(clk),
      .srst(srst),
      .devAddr({SLAVE_ADDR[6:1], addrSel_ff}),
      .scl(scl),
      .sdaIn(sdaIn),
      .sdaOut(sdaOut),
      .sdaOeN(sdaOeN),
      .byteStb(byteStb),
      .firstData(firstData),
      .byteData(byteData),
      .rdStb(rdStb),
      .rdData(rdData)
   );

   // bus stays live in low power: nothing here looks at run
   assign wrStb = byteStb && !firstData;

   // pointer is write-only, loaded by the first data byte
   always_ff @(posedge clk) begin
      if (srst) begin
         ptr_ff <= 8'h00;
      end else if (byteStb && firstData) begin
         ptr_ff <= byteData;
      end
   end

   ////////////////////////////////////////////////////////////////
   // strap capture after power-up release, once only
   always_ff @(posedge clk) begin
      if (srst) begin
         strapDone_ff <= 1'b0;
         nandMode_ff <= 1'b0;
         addrSel_ff <= 1'b0;
      end else if (!strapDone_ff) begin
         strapDone_ff <= 1'b1;
         nandMode_ff <= rstPinIn;
         addrSel_ff <= treeAddrIn;
      end
   end

   // tree output is registered, so toggles show one cycle later
   always_ff @(posedge clk) begin
      if (srst) begin
         treeOut_ff <= 1'b0;
      end else begin
         treeOut_ff <= ~&treeIn;
      end
   end

   assign treeAddrOut = treeOut_ff;
   assign treeAddrOeN = !nandMode_ff;
   assign nandMode = nandMode_ff;

   ////////////////////////////////////////////////////////////////
   // reset sources; own pulse must not reset ourselves
   assign pinRst = strapDone_ff && !nandMode_ff && !rstPinIn
      && !pulseBusy;
   assign initReq = cfg1_ff[CFG1_INIT];
   assign softRst = pinRst || initReq;

   // primary configuration; init resets the init bit too
   always_ff @(posedge clk) begin
      if (srst || softRst) begin
         cfg1_ff <= CFG1_RST;
      end else if (wrStb && ptr_ff == ADDR_CFG1) begin
         cfg1_ff <= byteData;
      end else if (pulseGo) begin
         cfg1_ff[CFG1_RST_PULSE] <= 1'b0;
      end
   end

   // secondary configuration; lock bits survive all but power-on
   always_ff @(posedge clk) begin
      if (srst) begin
         cfg2_ff <= CFG2_RST;
      end else if (softRst) begin
         cfg2_ff <= (CFG2_RST & ~CFG2_LOCK_MSK)
            | (cfg2_ff & CFG2_LOCK_MSK);
      end else if (wrStb && ptr_ff == ADDR_CFG2) begin
         cfg2_ff <= byteData | (cfg2_ff & CFG2_LOCK_MSK);
      end
   end

   // mask and channel mode: all reset sources
   always_ff @(posedge clk) begin
      if (srst || softRst) begin
         mask2_ff <= MASK2_RST;
         chmode_ff <= CHMODE_RST;
      end else if (wrStb) begin
         if (ptr_ff == ADDR_MASK2) begin
            mask2_ff <= byteData;
         end
         if (ptr_ff == ADDR_CHMODE) begin
            chmode_ff <= byteData;
         end
      end
   end

   // test register keeps its value through soft init
   always_ff @(posedge clk) begin
      if (srst || pinRst) begin
         test_ff <= TEST_RST;
      end else if (wrStb && ptr_ff == ADDR_TEST) begin
         test_ff <= byteData;
      end
   end

   // analog output value: only power-on touches it
   always_ff @(posedge clk) begin
      if (srst) begin
         aout_ff <= AOUT_RST;
      end else if (wrStb && ptr_ff == ADDR_AOUT) begin
         aout_ff <= byteData;
      end
   end

   // trip points: locked ones hold against writes and soft resets
   always_ff @(posedge clk) begin
      if (srst) begin
         tripLoc_ff <= TRIP_LOC_RST;
         tripRem_ff <= TRIP_REM_RST;
      end else begin
         if (!cfg2_ff[CFG2_LOCK_LOC]) begin
            if (softRst) begin
               tripLoc_ff <= TRIP_LOC_RST;
            end else if (wrStb && ptr_ff == ADDR_TRIP_LOC) begin
               tripLoc_ff <= byteData;
            end
         end
         if (!cfg2_ff[CFG2_LOCK_REM]) begin
            if (softRst) begin
               tripRem_ff <= TRIP_REM_RST;
            end else if (wrStb && ptr_ff == ADDR_TRIP_REM) begin
               tripRem_ff <= byteData;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // read mux; everything not held here comes from value logic
   assign extAddr = ptr_ff;
   always_comb begin
      unique case (ptr_ff)
         ADDR_CFG1: rdData = cfg1_ff;
         ADDR_CFG2: rdData = cfg2_ff;
         ADDR_MASK2: rdData = mask2_ff;
         ADDR_CHMODE: rdData = chmode_ff;
         ADDR_TEST: rdData = test_ff;
         ADDR_AOUT: rdData = aout_ff;
         ADDR_TRIP_LOC: rdData = tripLoc_ff;
         ADDR_TRIP_REM: rdData = tripRem_ff;
         default: rdData = extRdData;
      endcase
   end

   ////////////////////////////////////////////////////////////////
   // monitoring loop control
   assign shutdown = test_ff[TEST_SHDN];
   assign run = cfg1_ff[CFG1_START] && !cfg1_ff[CFG1_INT_CLR]
      && !shutdown && !nandMode_ff;
   assign monitorRun = run;
   assign aoutEnable = !shutdown;
   assign aoutValue = aout_ff;
   assign thermAcpi = cfg2_ff[CFG2_THERMAL_ALARM_PIN_MODE];
   assign chanMode = chmode_ff;

   // common start strobe for both measurement engines
   always_ff @(posedge clk) begin
      if (srst) begin
         runQ_ff <= 1'b0;
      end else begin
         runQ_ff <= run;
      end
   end
   assign convStart = run && !runQ_ff;
   assign fanStart = convStart;

   ////////////////////////////////////////////////////////////////
   // reset pin pulse; request waits until the enable is set
   assign pulseGo = cfg1_ff[CFG1_RST_PULSE] && mask2_ff[MASK2_RST_EN]
      && !pulseBusy && !initReq;

   pulse_timer #(.CYCLES(PULSE_CYC)) u_pulse (
      .clk(clk),
      .srst(srst),
      .start(pulseGo),
      .busy(pulseBusy)
   );

   assign rstPinOut = 1'b0;
   assign rstPinOeN = !pulseBusy;

   ////////////////////////////////////////////////////////////////
   // interrupt pin, open drain, active low
   always_ff @(posedge clk) begin
      if (srst) begin
         intDrv_ff <= 1'b0;
      end else begin
         intDrv_ff <= cfg1_ff[CFG1_INT_EN]
            && !cfg1_ff[CFG1_INT_CLR]
            && (otherIrq || (tempIrq
            && !cfg2_ff[CFG2_TEMP_MASK]));
      end
   end
   assign intPinOut = 1'b0;
   assign intPinOeN = !intDrv_ff;

   // thermal alarm latch; a held clear bit blocks reassertion
   always_ff @(posedge clk) begin
      if (srst || softRst) begin
         thermLatch_ff <= 1'b0;
      end else if (cfg1_ff[CFG1_THERMAL_ALARM_PIN_CLR]) begin
         thermLatch_ff <= 1'b0;
      end else if (thermEvent) begin
         thermLatch_ff <= 1'b1;
      end
   end
   assign thermPinOut = 1'b0;
   assign thermPinOeN = !(cfg1_ff[CFG1_THERMAL_ALARM_PIN_EN]
      && thermLatch_ff);

   ////////////////////////////////////////////////////////////////
   // checks
   AST_INIT_SELFCLR: assert property (@(posedge clk)
      disable iff (srst) cfg1_ff[CFG1_INIT] |=> !cfg1_ff[CFG1_INIT]
      ##0 cfg1_ff == CFG1_RST)
      else $error("init bit did not clear");
   AST_TREE: assert property (@(posedge clk) disable iff (srst)
      nandMode_ff && !treeAddrOeN |-> treeAddrOut ==
      ~&$past(treeIn))
      else $error("tree output wrong");
   AST_PULSE_EN: assert property (@(posedge clk)
      disable iff (srst) $fell(rstPinOeN) |->
      $past(mask2_ff[MASK2_RST_EN]) && !cfg1_ff[CFG1_RST_PULSE])
      else $error("reset pulse without enable");
   AST_INT_OFF: assert property (@(posedge clk)
      disable iff (srst) !cfg1_ff[CFG1_INT_EN] ##1 !cfg1_ff[CFG1_INT_EN]
      |-> intPinOeN)
      else $error("interrupt driven while disabled");
   AST_INT_CLR: assert property (@(posedge clk)
      disable iff (srst) cfg1_ff[CFG1_INT_CLR] |-> !monitorRun ##1
      (intPinOeN || !$past(cfg1_ff[CFG1_INT_CLR])))
      else $error("interrupt clear ignored");
   AST_TEMP_MASK: assert property (@(posedge clk)
      disable iff (srst) cfg2_ff[CFG2_TEMP_MASK] && !otherIrq
      |=> intPinOeN)
      else $error("masked temperature interrupt seen");
   AST_LOCK: assert property (@(posedge clk) disable iff (srst)
      cfg2_ff[CFG2_LOCK_LOC] |=> $stable(tripLoc_ff)
      && cfg2_ff[CFG2_LOCK_LOC])
      else $error("locked trip point changed");
   AST_SHDN: assert property (@(posedge clk) disable iff (srst)
      test_ff[TEST_SHDN] |-> !aoutEnable && !monitorRun
      && !convStart)
      else $error("shutdown not honoured");
   AST_THERMAL_ALARM_PIN_EN: assert property (@(posedge clk)
      disable iff (srst) !cfg1_ff[CFG1_THERMAL_ALARM_PIN_EN] |-> thermPinOeN)
      else $error("thermal alarm driven while disabled");
   COV_START: cover property (@(posedge clk) disable iff (srst)
      convStart && fanStart);
   COV_PULSE: cover property (@(posedge clk) disable iff (srst)
      $fell(rstPinOeN));
   COV_TREE: cover property (@(posedge clk) disable iff (srst)
      nandMode_ff && $changed(treeAddrOut));
   COV_READ: cover property (@(posedge clk) disable iff (srst)
      rdStb && ptr_ff == ADDR_CFG1);
endmodule

//--- monitor_pkg.sv
// Purpose: shared constants of the monitor control bank
// Assumes: 100 MHz clock, 8-bit registers
// Notes: offsets, field positions, reset values, timing
package monitor_pkg;
   // register offsets
   localparam logic [7:0] ADDR_TRIP_LOC = 8'h13;
   localparam logic [7:0] ADDR_TRIP_REM = 8'h14;
   localparam logic [7:0] ADDR_TEST = 8'h15;
   localparam logic [7:0] ADDR_CHMODE = 8'h16;
   localparam logic [7:0] ADDR_AOUT = 8'h19;
   localparam logic [7:0] ADDR_CFG1 = 8'h40;
   localparam logic [7:0] ADDR_MASK2 = 8'h44;
   localparam logic [7:0] ADDR_CFG2 = 8'h4a;
   // primary configuration fields
   localparam int CFG1_START = 0;
   localparam int CFG1_INT_EN = 1;
   localparam int CFG1_THERMAL_ALARM_PIN_EN = 2;
   localparam int CFG1_INT_CLR = 3;
   localparam int CFG1_RST_PULSE = 4;
   localparam int CFG1_THERMAL_ALARM_PIN_CLR = 6;
   localparam int CFG1_INIT = 7;
   // secondary configuration, mask and test fields
   localparam int CFG2_TEMP_MASK = 0;
   localparam int CFG2_LOCK_LOC = 1;
   localparam int CFG2_LOCK_REM = 2;
   localparam int CFG2_THERMAL_ALARM_PIN_MODE = 3;
   localparam logic [7:0] CFG2_LOCK_MSK = 8'h06;
   localparam int MASK2_RST_EN = 7;
   localparam int TEST_SHDN = 0;
   // reset values
   localparam logic [7:0] CFG1_RST = 8'h08;
   localparam logic [7:0] CFG2_RST = 8'h00;
   localparam logic [7:0] CHMODE_RST = 8'h00;
   localparam logic [7:0] MASK2_RST = 8'h00;
   localparam logic [7:0] TEST_RST = 8'h00;
   localparam logic [7:0] AOUT_RST = 8'hff;
   localparam logic [7:0] TRIP_LOC_RST = 8'h46;
   localparam logic [7:0] TRIP_REM_RST = 8'h55;
   // timing
   localparam int CLK_PERIOD_NS = 10;
   localparam int RST_PULSE_MS = 45;
   localparam int RST_PULSE_CYC = RST_PULSE_MS * 1000000 / CLK_PERIOD_NS;
   // serial bus
   localparam logic [6:0] SLAVE_ADDR = 7'h2c;
endpackage

//--- pulse_timer.sv
// Purpose: one-shot low pulse timer for the reset pin
// Assumes: start is a one-cycle pulse
// Notes: start while busy is ignored
`timescale 1ns/1ns
module pulse_timer #(
   parameter int CYCLES = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic start,
   output logic busy
);
   logic [31:0] cnt_ff;

   // count down the pulse length
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_ff <= 32'h0;
      end else if (start && cnt_ff == 32'h0) begin
         cnt_ff <= 32'(CYCLES);
      end else if (cnt_ff != 32'h0) begin
         cnt_ff <= cnt_ff - 32'h1;
      end
   end

   assign busy = (cnt_ff != 32'h0);
endmodule

//--- serial_slave.sv
// Purpose: byte-level serial management bus slave
// Assumes: scl and sda sampled synchronously, slow bus
// Notes: sda is open drain; sdaOeN low while pulling low
`timescale 1ns/1ns
module serial_slave (
   input wire logic clk,
   input wire logic srst,
   input wire logic [6:0] devAddr,
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   output logic byteStb,
   output logic firstData,
   output logic [7:0] byteData,
   output logic rdStb,
   input wire logic [7:0] rdData
);
   typedef enum logic [2:0] {
      S_IDLE, S_RX, S_ACK, S_TX, S_TXACK
   } st_t;
   st_t st_ff;
   logic sclQ_ff, sdaQ_ff, isAddr_ff, isRd_ff, pull_ff;
   logic isFirst_ff;
   logic [3:0] bit_ff;
   logic [7:0] sh_ff;
   logic sclRise, sclFall, startC, stopC;

   assign sclRise = scl && !sclQ_ff;
   assign sclFall = !scl && sclQ_ff;
   assign startC = scl && sclQ_ff && sdaQ_ff && !sdaIn;
   assign stopC = scl && sclQ_ff && !sdaQ_ff && sdaIn;
   assign sdaOut = 1'b0;
   assign sdaOeN = !pull_ff;

   // bit engine; start and stop override any state
   always_ff @(posedge clk) begin
      if (srst) begin
         st_ff <= S_IDLE;
         sclQ_ff <= 1'b1;
         sdaQ_ff <= 1'b1;
         isAddr_ff <= 1'b0;
         isRd_ff <= 1'b0;
         isFirst_ff <= 1'b0;
         pull_ff <= 1'b0;
         bit_ff <= 4'h0;
         sh_ff <= 8'h00;
         byteStb <= 1'b0;
         firstData <= 1'b0;
         byteData <= 8'h00;
         rdStb <= 1'b0;
      end else begin
         sclQ_ff <= scl;
         sdaQ_ff <= sdaIn;
         byteStb <= 1'b0;
         rdStb <= 1'b0;
         if (startC) begin
            st_ff <= S_RX;
            isAddr_ff <= 1'b1;
            bit_ff <= 4'h0;
            pull_ff <= 1'b0;
         end else if (stopC) begin
            st_ff <= S_IDLE;
            pull_ff <= 1'b0;
         end else begin
            unique case (st_ff)
               S_IDLE: ;
               S_RX: begin
                  if (sclRise) begin
                     sh_ff <= {sh_ff[6:0], sdaIn};
                     bit_ff <= bit_ff + 4'h1;
                  end else if (sclFall && bit_ff == 4'h8) begin
                     bit_ff <= 4'h0;
                     if (isAddr_ff && sh_ff[7:1] != devAddr) begin
                        st_ff <= S_IDLE;
                     end else begin
                        st_ff <= S_ACK;
                        pull_ff <= 1'b1;
                        if (isAddr_ff) begin
                           isRd_ff <= sh_ff[0];
                           isFirst_ff <= 1'b1;
                        end else begin
                           byteStb <= 1'b1;
                           byteData <= sh_ff;
                           firstData <= isFirst_ff;
                           isFirst_ff <= 1'b0;
                        end
                     end
                  end
               end
               S_ACK: begin
                  if (sclFall) begin
                     isAddr_ff <= 1'b0;
                     if (isRd_ff) begin
                        st_ff <= S_TX;
                        sh_ff <= {rdData[6:0], 1'b0};
                        pull_ff <= !rdData[7];
                        rdStb <= 1'b1;
                        bit_ff <= 4'h1;
                     end else begin
                        st_ff <= S_RX;
                        pull_ff <= 1'b0;
                     end
                  end
               end
               S_TX: begin
                  if (sclFall) begin
                     if (bit_ff == 4'h8) begin
                        st_ff <= S_TXACK;
                        pull_ff <= 1'b0;
                     end else begin
                        pull_ff <= !sh_ff[7];
                        sh_ff <= {sh_ff[6:0], 1'b0};
                        bit_ff <= bit_ff + 4'h1;
                     end
                  end
               end
               S_TXACK: begin
                  // master nack ends the read
                  if (sclRise && sdaIn) begin
                     st_ff <= S_IDLE;
                  end else if (sclRise) begin
                     st_ff <= S_ACK;
                  end
               end
            endcase
         end
      end
   end
endmodule

//--- smbus_host.sv
// Purpose: serial management bus host model
// Assumes: open-drain data with pull-up, no clock stretching
// Notes: four clk per phase; scl held high between frames
`timescale 1ns/1ns
module smbus_host
   import monitor_pkg::*;
(
   input wire logic clk,
   input wire logic sdaBus,
   output logic scl,
   output logic sdaLow,
   output int nak
);
   // bus idle at time zero
   initial begin
      scl = 1'b1;
      sdaLow = 1'b0;
      nak = 0;
   end
   ///////////////////////////////////////////////////////////////////
   // one phase: wait, then set clock and data pull together
   task ph(input logic c, input logic l);
      repeat (4) @(posedge clk);
      scl <= c;
      sdaLow <= l;
   endtask
   // data falls while clock high; also serves as repeated start
   task start();
      ph(1'b0, 1'b0);
      ph(1'b1, 1'b0);
      ph(1'b1, 1'b1);
   endtask
   task stop();
      ph(1'b0, sdaLow);
      ph(1'b0, 1'b1);
      ph(1'b1, 1'b1);
      ph(1'b1, 1'b0);
   endtask
   // msb first, then answer bit; data moves only with clock low
   task xfer(input logic [8:0] s, output logic [8:0] r);
      for (int i = 8; i >= 0; i--) begin
         ph(1'b0, sdaLow);
         ph(1'b0, !s[i]);
         ph(1'b1, !s[i]);
         r[i] = sdaBus;
      end
   endtask
   // byte that the device must acknowledge
   task put(input logic [7:0] d);
      logic [8:0] r;
      xfer({d, 1'b1}, r);
      if (r[0] !== 1'b0) nak++;
   endtask
   // first byte after address loads pointer, next one the register
   task wr(input logic [7:0] p, input logic [7:0] d);
      start();
      put({SLAVE_ADDR[6:1], 2'b00});
      put(p);
      put(d);
      stop();
   endtask
   // pointer, repeated start, one byte read, not acknowledged
   task rd(input logic [7:0] p, output logic [7:0] d);
      logic [8:0] r;
      start();
      put({SLAVE_ADDR[6:1], 2'b00});
      put(p);
      start();
      put({SLAVE_ADDR[6:1], 2'b01});
      xfer(9'h1ff, r);
      d = r[8:1];
      stop();
   endtask
endmodule

//--- tb_monitor_config_control.sv
// Purpose: self-checking bench of the monitor control bank
// Assumes: host model smbus_host, reset pulse shortened to PC
// Notes: seeded random data mixed with corner cases
`timescale 1ns/1ns
module tb_monitor_config_control
   import monitor_pkg::*;
;
   localparam int PC = 20;
   logic clk = 1'b0, srst = 1'b1, rstExt = 1'b0, treeAddrIn = 1'b0;
   logic tempIrq = 1'b0, otherIrq = 1'b0, thermEvent = 1'b0;
   logic [7:0] treeIn = 8'hff, extRdData = 8'h00;
   logic sdaOut, sdaOeN, rstPinOut, rstPinOeN, treeAddrOut, treeAddrOeN;
   logic intPinOut, intPinOeN, thermPinOut, thermPinOeN, monitorRun;
   logic convStart, fanStart, shutdown, aoutEnable, thermAcpi, nandMode;
   logic [7:0] aoutValue, chanMode, extAddr, rd, rnd, p;
   logic scl, sdaLow, sdaBus, rstPinIn, e;
   logic [7:0] tv [5] = '{8'h05, 8'h01, 8'h05, 8'h45, 8'h05};
   logic tx [5] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b1};
   int fails = 0, comparisons = 0, nak, lowCnt = 0, runCnt = 0, skew = 0;
   ///////////////////////////////////////////////////////////////////
   // pull-up on data; pin reads low while the device pulses it
   assign sdaBus = !sdaLow && (sdaOeN || sdaOut);
   assign rstPinIn = rstPinOeN ? rstExt : rstPinOut;
   initial forever #5 clk = !clk;
   monitor_config_control #(.TREE_W(8), .PULSE_CYC(PC)) i_dut (
      .clk(clk), .srst(srst), .scl(scl), .sdaIn(sdaBus), .sdaOut(sdaOut),
      .sdaOeN(sdaOeN), .rstPinIn(rstPinIn), .rstPinOut(rstPinOut),
      .rstPinOeN(rstPinOeN), .treeIn(treeIn), .treeAddrIn(treeAddrIn),
      .treeAddrOut(treeAddrOut), .treeAddrOeN(treeAddrOeN),
      .tempIrq(tempIrq), .otherIrq(otherIrq), .thermEvent(thermEvent),
      .intPinOut(intPinOut), .intPinOeN(intPinOeN),
      .thermPinOut(thermPinOut), .thermPinOeN(thermPinOeN),
      .monitorRun(monitorRun), .convStart(convStart), .fanStart(fanStart),
      .shutdown(shutdown), .aoutEnable(aoutEnable), .aoutValue(aoutValue),
      .thermAcpi(thermAcpi), .chanMode(chanMode), .extAddr(extAddr),
      .extRdData(extRdData), .nandMode(nandMode));
   smbus_host i_host (.clk(clk), .sdaBus(sdaBus), .scl(scl),
      .sdaLow(sdaLow), .nak(nak));
   // pulse width and start pairing, counted every cycle
   always @(posedge clk) begin
      if (!rstPinOeN) lowCnt++;
      if (convStart === 1'b1) runCnt++;
      if (convStart !== fanStart) skew++;
   end
   ///////////////////////////////////////////////////////////////////
   function automatic logic intExp(logic en, clr, mask, tmp, oth);
      return !(en && !clr && (oth || (tmp && !mask)));
   endfunction
   task chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task final_report();
      $display("comparisons=%0d fails=%0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // strap level sits on the pin until two edges after release
   task boot(input logic strap);
      srst <= 1'b1;
      rstExt <= strap;
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      repeat (2) @(posedge clk);
      rstExt <= 1'b1;
      repeat (2) @(posedge clk);
   endtask
   ///////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      void'($urandom(32'h5421c558));
      boot(1'b0);
      i_host.rd(ADDR_CFG1, rd);
      chk(rd, CFG1_RST);
      i_host.rd(ADDR_TRIP_LOC, rd);
      chk(rd, TRIP_LOC_RST);
      chk(aoutValue, AOUT_RST);
      chk({5'h00, monitorRun, intPinOeN, nandMode}, 8'h02);
      chk({5'h00, rstPinOeN, thermPinOeN, treeAddrOeN}, 8'h07);
      // low power: random mode bytes and unmapped reads
      for (int i = 0; i < 4; i++) begin
         rnd = 8'($urandom);
         i_host.wr(ADDR_CHMODE, rnd);
         chk(chanMode, rnd);
         extRdData <= 8'($urandom);
         p = 8'h20 + 8'($urandom_range(9));
         i_host.rd(p, rd);
         chk(rd, extRdData);
         chk(extAddr, p);
      end
      // every request, mask, enable and clear combination
      for (int k = 0; k < 32; k++) begin
         tempIrq <= k[1];
         otherIrq <= k[0];
         i_host.wr(ADDR_CFG2, {4'h0, k[0], 2'b00, k[2]});
         i_host.wr(ADDR_CFG1, {4'h0, k[3], 1'b1, !k[4], 1'b1});
         e = intExp(!k[4], k[3], k[2], k[1], k[0]);
         chk({7'h00, intPinOeN | intPinOut}, {7'h00, e});
         chk({7'h00, monitorRun}, {7'h00, !k[3]});
         chk({7'h00, thermAcpi}, {7'h00, k[0]});
      end
      // alarm latch: mask has no say, clear wins while set
      tempIrq <= 1'b0;
      otherIrq <= 1'b0;
      for (int j = 0; j < 5; j++) begin
         i_host.wr(ADDR_CFG1, tv[j]);
         thermEvent <= (j == 0 || j == 3);
         repeat (2) @(posedge clk);
         thermEvent <= 1'b0;
         repeat (2) @(posedge clk);
         chk({7'h00, thermPinOeN | thermPinOut}, {7'h00, tx[j]});
      end
      // trip lock; the remote trip keeps its power-up value
      rnd = 8'($urandom);
      i_host.wr(ADDR_TRIP_LOC, rnd);
      i_host.wr(ADDR_CFG2, CFG2_LOCK_MSK);
      i_host.wr(ADDR_TRIP_LOC, ~rnd);
      i_host.wr(ADDR_TRIP_REM, ~rnd);
      i_host.rd(ADDR_TRIP_LOC, rd);
      chk(rd, rnd);
      i_host.rd(ADDR_TRIP_REM, rd);
      chk(rd, TRIP_REM_RST);
      // pulse request waits for its enable, then self-clears
      lowCnt = 0;
      i_host.wr(ADDR_CFG1, 8'h10);
      repeat (PC) @(posedge clk);
      chk(8'(lowCnt), 8'h00);
      i_host.wr(ADDR_MASK2, 8'h80);
      repeat (PC + 4) @(posedge clk);
      chk(8'(lowCnt), 8'(PC));
      i_host.rd(ADDR_CFG1, rd);
      chk(rd, 8'h00);
      // shutdown and back, then soft init sparing test and output
      i_host.wr(ADDR_AOUT, rnd);
      i_host.wr(ADDR_CFG1, 8'h01);
      i_host.wr(ADDR_TEST, 8'h01);
      chk({5'h00, shutdown, aoutEnable, monitorRun}, 8'h04);
      i_host.wr(ADDR_TEST, 8'h00);
      chk({5'h00, shutdown, aoutEnable, monitorRun}, 8'h03);
      i_host.wr(ADDR_TEST, 8'h01);
      i_host.wr(ADDR_CHMODE, 8'h5a);
      i_host.wr(ADDR_CFG1, 8'h81);
      i_host.rd(ADDR_CFG1, rd);
      chk(rd, CFG1_RST);
      chk(chanMode, CHMODE_RST);
      chk({aoutValue[6:0], shutdown}, {rnd[6:0], 1'b1});
      i_host.wr(ADDR_TEST, 8'h00);
      // external low on the pin; output register is left alone
      i_host.wr(ADDR_CHMODE, rnd | 8'h01);
      rstExt <= 1'b0;
      repeat (3) @(posedge clk);
      rstExt <= 1'b1;
      repeat (2) @(posedge clk);
      chk(chanMode, CHMODE_RST);
      chk(aoutValue, rnd);
      chk(8'(nak), 8'h00);
      chk({7'h00, runCnt > 0 && skew == 0}, 8'h01);
      // strap high selects the tree test; last pass all ones
      boot(1'b1);
      chk({6'h00, nandMode, treeAddrOeN}, 8'h02);
      for (int i = 0; i <= 8; i++) begin
         treeIn <= 8'hff ^ (8'h01 << i);
         repeat (3) @(posedge clk);
         chk({7'h00, treeAddrOut}, 8'(i < 8));
      end
      final_report();
   end
   // hang guard
   initial begin
      repeat (100000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule
